// ==== inc/dual_adc_pkg.sv ====
// constants for the dual converter register bank
package dual_adc_pkg;
    // command byte layout
    localparam int CMD_WEN_BIT = 7;
    localparam int CMD_DIR_BIT = 6;
    localparam int CMD_BITS = 8;
    // register selector values
    localparam logic [3:0] SEL_STATUS = 4'h0;
    localparam logic [3:0] SEL_MODE = 4'h1;
    localparam logic [3:0] SEL_MAIN = 4'h2;
    localparam logic [3:0] SEL_AUX = 4'h3;
    localparam logic [3:0] SEL_PORT = 4'h4;
    localparam logic [3:0] SEL_DECIM = 4'h5;
    // reset values
    localparam logic [7:0] STATUS_RST = 8'h00;
    localparam logic [7:0] MODE_RST = 8'h00;
    localparam logic [7:0] MAIN_RST = 8'h07;
    localparam logic [7:0] AUX_RST = 8'h01;
    localparam logic [15:0] PORT_RST = 16'h0000;
    localparam logic [7:0] DECIM_RST = 8'h45;
    // bit masks of implemented bits, fixed zeros cleared
    localparam logic [7:0] STATUS_MASK = 8'hFD;
    localparam logic [7:0] MODE_MASK = 8'h5F;
    localparam logic [7:0] MAIN_MASK = 8'hFF;
    localparam logic [7:0] AUX_MASK = 8'hF9;
    localparam logic [15:0] PORT_MASK = 16'hDFFF;
    localparam logic [7:0] DECIM_MASK = 8'hFF;
    // transfer lengths in serial clocks
    localparam logic [4:0] LEN_BYTE = 5'h08;
    localparam logic [4:0] LEN_WORD = 5'h10;
    // consecutive high data bits that resync the link
    localparam logic [5:0] RESYNC_ONES = 6'h20;
    typedef enum logic [2:0] {
        ST_CMD = 3'b001,
        ST_WR = 3'b010,
        ST_RD = 3'b100
    } link_state_t;
endpackage

// ==== rtl/dual_adc_regs.sv ====
// serial register bank of the dual converter
//
// Function
// R1: every access opens with a command write
// R2: command holds gate, direction, zeros, selector
// R3: next transfer goes to selected register
// R4: status read-only, eight bits, resets zero
// R5: status bits: ready, cal, ref, faults, lock
// R6: mode register eight bits, reset zero
// R7: mode bits: buffer, pairing, osc keep, mode
// R8: main control eight bits, reset 0x07
// R9: main bits: enable, length, input, polarity, span
// R10: aux control eight bits, reset 0x01
// R11: aux bits: enable, input, polarity, span
// R12: port control sixteen bits, reset zero
// R13: port control power, current, gpio fields
// R14: decimation eight bits, reset 0x45
// R15: one decimation rate for both converters
// R16: set means one, cleared means zero
// R17: after transfer return to command state
// R18: 32 high data clocks reset the device
// R19: fixed zero bits write and read zero
// R20: writes to read-only complete without effect
`timescale 1ns/1ps
`default_nettype none
module dual_adc_regs
    import dual_adc_pkg::*;
(
    input wire logic ref_clk,
    input wire logic reset_n,
    input wire logic sclk,
    input wire logic din,
    input wire logic cs_n,
    output logic dout,
    output logic dout_oe_n,
    input wire logic main_result_ready,
    input wire logic aux_result_ready,
    input wire logic cal_busy,
    input wire logic missing_vref_flag,
    input wire logic main_fault,
    input wire logic aux_fault,
    input wire logic clk_locked,
    output logic [7:0] op_config,
    output logic [7:0] main_conv_ctl,
    output logic [7:0] aux_conv_ctl,
    output logic [15:0] port_excite_ctl,
    output logic [7:0] decimation_ratio,
    output logic [7:0] conv_status
);

    // width of the selected register
    function automatic logic [4:0] sel_len(input logic [3:0] sel);
        sel_len = (sel == SEL_PORT) ? LEN_WORD : LEN_BYTE;
    endfunction

    logic [2:0] sclk_sync;
    logic [1:0] din_sync;
    logic [1:0] cs_sync;
    logic [6:0] stat_s1;
    logic [6:0] stat_s2;
    link_state_t state;
    logic [3:0] sel;
    logic [4:0] bit_cnt;
    logic [15:0] in_sh;
    logic [15:0] out_sh;
    logic [5:0] ones_cnt;
    logic soft_rst;
    logic rise;
    logic fall;
    logic active;
    logic din_s;
    logic [7:0] cmd_byte;
    logic cmd_take;
    logic last_bit;
    logic wr_fire;
    logic [15:0] wr_data;
    logic [15:0] rd_value;

    // link pins are foreign to ref_clk; stage two is read, and stage three of sclk for edges
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            sclk_sync <= 3'h7;
            din_sync <= 2'h0;
            cs_sync <= 2'h3;
        end else begin
            sclk_sync <= {sclk_sync[1:0], sclk};
            din_sync <= {din_sync[0], din};
            cs_sync <= {cs_sync[0], cs_n};
        end
    end

    assign rise = sclk_sync[1] & ~sclk_sync[2];
    assign fall = ~sclk_sync[1] & sclk_sync[2];
    assign active = ~cs_sync[1];
    assign din_s = din_sync[1];
    assign cmd_byte = {in_sh[6:0], din_s};
    assign cmd_take = rise & active & (state == ST_CMD) & (bit_cnt == LEN_BYTE - 5'h01); // R1
    assign last_bit = (bit_cnt == sel_len(sel) - 5'h01);
    assign wr_fire = rise & active & (state == ST_WR) & last_bit;
    assign wr_data = {in_sh[14:0], din_s};

    // status flags come from analog logic on other clocks
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            stat_s1 <= 7'h00;
            stat_s2 <= 7'h00;
        end else begin
            stat_s1 <= {main_result_ready, aux_result_ready, cal_busy, missing_vref_flag,
                        main_fault, aux_fault, clk_locked};
            stat_s2 <= stat_s1;
        end
    end

    // status byte, bit one held at zero
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            conv_status <= STATUS_RST; // R4
        end else if (soft_rst) begin
            conv_status <= STATUS_RST;
        end else begin
            conv_status <= {stat_s2[6:1], 1'b0, stat_s2[0]} & STATUS_MASK; // R5 R16
        end
    end

    // resync counter: counts high data bits, any low bit restarts it
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            ones_cnt <= 6'h00;
            soft_rst <= 1'b0;
        end else begin
            soft_rst <= 1'b0;
            if (soft_rst) begin
                ones_cnt <= 6'h00;
            end else if (rise && active) begin
                if (!din_s) begin
                    ones_cnt <= 6'h00;
                end else if (ones_cnt == RESYNC_ONES - 6'h01) begin
                    ones_cnt <= 6'h00;
                    soft_rst <= 1'b1; // R18
                end else begin
                    ones_cnt <= ones_cnt + 6'h01;
                end
            end
        end
    end

    // readback value, left aligned so the top bit goes out first
    always_comb begin
        rd_value = 16'h0000;
        case (cmd_byte[3:0])
            SEL_STATUS: rd_value = {conv_status, 8'h00};
            SEL_MODE: rd_value = {op_config & MODE_MASK, 8'h00}; // R19
            SEL_MAIN: rd_value = {main_conv_ctl, 8'h00};
            SEL_AUX: rd_value = {aux_conv_ctl & AUX_MASK, 8'h00};
            SEL_PORT: rd_value = port_excite_ctl & PORT_MASK;
            SEL_DECIM: rd_value = {decimation_ratio, 8'h00};
            default: rd_value = 16'h0000;
        endcase
    end

    // link sequencer; an all-ones command has the gate high and is dropped,
    // which keeps a resync stream from starting a transfer
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            state <= ST_CMD; // R17
            sel <= 4'h0;
            bit_cnt <= 5'h00;
            in_sh <= 16'h0000;
            out_sh <= 16'h0000;
        end else if (soft_rst) begin
            state <= ST_CMD; // R18
            bit_cnt <= 5'h00;
            in_sh <= 16'h0000;
        end else if (rise && active) begin
            in_sh <= wr_data;
            case (state)
                ST_CMD: begin
                    if (cmd_take) begin
                        bit_cnt <= 5'h00;
                        if (!cmd_byte[CMD_WEN_BIT]) begin // R2
                            sel <= cmd_byte[3:0]; // R3
                            if (cmd_byte[CMD_DIR_BIT]) begin
                                state <= ST_RD;
                                out_sh <= rd_value;
                            end else begin
                                state <= ST_WR;
                            end
                        end
                    end else begin
                        bit_cnt <= bit_cnt + 5'h01;
                    end
                end
                ST_WR, ST_RD: begin
                    if (last_bit) begin
                        state <= ST_CMD; // R17 R20
                        bit_cnt <= 5'h00;
                    end else begin
                        bit_cnt <= bit_cnt + 5'h01;
                    end
                end
                default: begin
                    state <= ST_CMD;
                    bit_cnt <= 5'h00;
                end
            endcase
        end else if (fall && active && state == ST_RD) begin
            out_sh <= {out_sh[14:0], 1'b0};
        end
    end

    // serial output changes on falling edges so the host samples on rising
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            dout <= 1'b0;
            dout_oe_n <= 1'b1;
        end else begin
            dout_oe_n <= ~(active && state == ST_RD);
            if (fall && active && state == ST_RD) begin
                dout <= out_sh[15];
            end
        end
    end

    // writable registers; status is absent here so writes to it vanish
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            op_config <= MODE_RST; // R6
            main_conv_ctl <= MAIN_RST; // R8
            aux_conv_ctl <= AUX_RST; // R10
            port_excite_ctl <= PORT_RST; // R12
            decimation_ratio <= DECIM_RST; // R14
        end else if (soft_rst) begin
            op_config <= MODE_RST;
            main_conv_ctl <= MAIN_RST;
            aux_conv_ctl <= AUX_RST;
            port_excite_ctl <= PORT_RST;
            decimation_ratio <= DECIM_RST;
        end else if (wr_fire) begin
            case (sel)
                SEL_MODE: op_config <= wr_data[7:0] & MODE_MASK; // R7 R19
                SEL_MAIN: main_conv_ctl <= wr_data[7:0] & MAIN_MASK; // R9
                SEL_AUX: aux_conv_ctl <= wr_data[7:0] & AUX_MASK; // R11 R19
                SEL_PORT: port_excite_ctl <= wr_data & PORT_MASK; // R13 R19
                // one ratio drives both converters' filters
                SEL_DECIM: decimation_ratio <= wr_data[7:0] & DECIM_MASK; // R15
                default: ;
            endcase
        end
    end

    sequence cmd_seen;
        cmd_take && !cmd_byte[CMD_WEN_BIT];
    endsequence

    sequence write_done;
        wr_fire && sel == SEL_MODE;
    endsequence

    cmd_only_a: assert property (@(posedge ref_clk) disable iff (!reset_n) // R1
        state == ST_CMD && !cmd_take |=> state == ST_CMD)
        else $error("transfer started without command");

    wen_gate_a: assert property (@(posedge ref_clk) disable iff (!reset_n) // R2
        cmd_take && cmd_byte[CMD_WEN_BIT] && !soft_rst |=> state == ST_CMD)
        else $error("gated command was accepted");

    read_dir_a: assert property (@(posedge ref_clk) disable iff (!reset_n) // R2
        cmd_seen and cmd_byte[CMD_DIR_BIT] && !soft_rst |=> state == ST_RD ##1 !dout_oe_n || !active)
        else $error("read command did not start read");

    mode_route_a: assert property (@(posedge ref_clk) disable iff (!reset_n) // R3
        write_done and !soft_rst |=> op_config == ($past(wr_data[7:0]) & MODE_MASK))
        else $error("mode write not routed");

    status_ro_a: assert property (@(posedge ref_clk) disable iff (!reset_n) // R20
        wr_fire && sel == SEL_STATUS |=> state == ST_CMD && $stable(op_config))
        else $error("status write misbehaved");

    zero_bits_a: assert property (@(posedge ref_clk) disable iff (!reset_n) // R19
        (op_config & ~MODE_MASK) == 8'h00 && (port_excite_ctl & ~PORT_MASK) == 16'h0000
        && (aux_conv_ctl & ~AUX_MASK) == 8'h00
        && conv_status[1] == 1'b0)
        else $error("fixed zero bit set");

    resync_a: assert property (@(posedge ref_clk) disable iff (!reset_n) // R18
        soft_rst |=> state == ST_CMD && decimation_ratio == DECIM_RST && main_conv_ctl == MAIN_RST
        && aux_conv_ctl == AUX_RST)
        else $error("resync did not restore defaults");

    back_idle_a: assert property (@(posedge ref_clk) disable iff (!reset_n) // R17
        rise && active && state == ST_RD && last_bit |=> state == ST_CMD)
        else $error("no return to command state");

    // driver stays off outside a read phase, so a write never fights the host
    oe_off_a: assert property (@(posedge ref_clk) disable iff (!reset_n) // R2
        state != ST_RD |=> dout_oe_n)
        else $error("output driven outside read");

    write_idle_a: assert property (@(posedge ref_clk) disable iff (!reset_n) // R17
        wr_fire |=> state == ST_CMD)
        else $error("no return to command state after write");

endmodule
`default_nettype wire

// ==== test/host_link_model.sv ====
// host side model of the four-wire register link
`timescale 1ns/1ps
`default_nettype none
module host_link_model (
    input wire logic ref_clk,
    output logic sclk,
    output logic din,
    output logic cs_n,
    input wire logic dout,
    input wire logic dout_oe_n
);
    initial begin
        sclk = 1'b1;
        din = 1'b1;
        cs_n = 1'b1;
    end
    // n bits msb first, 8 ref_clk per half period gives 160 ns
    task automatic xfer(input logic [31:0] tx, input int n, output logic [31:0] rx, output int oe_lo);
        rx = '0;
        oe_lo = 0;
        @(negedge ref_clk);
        cs_n = 1'b0;
        for (int i = n - 1; i >= 0; i--) begin
            @(negedge ref_clk);
            sclk = 1'b0;
            din = tx[i];
            repeat (8) @(negedge ref_clk);
            // an undriven line reads as the inverse, so a stale bit cannot pass
            rx[i] = (dout_oe_n === 1'b0) ? dout : ~dout;
            if (dout_oe_n === 1'b0) oe_lo++;
            sclk = 1'b1;
            repeat (7) @(negedge ref_clk);
        end
        cs_n = 1'b1;
        // released line shows the inverse, never a stale level
        din = ~din;
    endtask
endmodule
`default_nettype wire

// ==== test/dual_adc_register_bank_test.sv ====
// self-checking bench for the dual converter register bank
`timescale 1ns/1ps
`default_nettype none
module dual_adc_register_bank_test;
    import dual_adc_pkg::*;
    logic ref_clk, reset_n, sclk, din, cs_n, dout, dout_oe_n;
    logic [6:0] pins;
    logic [7:0] op_config, main_conv_ctl, aux_conv_ctl, decimation_ratio, conv_status;
    logic [15:0] port_excite_ctl;
    logic [31:0] seed, rx;
    int error_cnt, checks, oe;
    int model [6];
    int unmapped_q [$] = '{6, 9, 15};
    logic [15:0] mask [6] = '{16'h0000, {8'h00, MODE_MASK}, {8'h00, MAIN_MASK}, {8'h00, AUX_MASK}, PORT_MASK,
        {8'h00, DECIM_MASK}};
    logic [15:0] rst [6] = '{16'h0000, {8'h00, MODE_RST}, {8'h00, MAIN_RST}, {8'h00, AUX_RST}, PORT_RST,
        {8'h00, DECIM_RST}};
    dual_adc_regs u_dual_adc_regs (.ref_clk(ref_clk), .reset_n(reset_n), .sclk(sclk), .din(din), .cs_n(cs_n),
        .dout(dout), .dout_oe_n(dout_oe_n), .main_result_ready(pins[6]), .aux_result_ready(pins[5]),
        .cal_busy(pins[4]), .missing_vref_flag(pins[3]), .main_fault(pins[2]), .aux_fault(pins[1]),
        .clk_locked(pins[0]), .op_config(op_config), .main_conv_ctl(main_conv_ctl), .aux_conv_ctl(aux_conv_ctl),
        .port_excite_ctl(port_excite_ctl), .decimation_ratio(decimation_ratio), .conv_status(conv_status));
    host_link_model u_host_link_model (.ref_clk(ref_clk), .sclk(sclk), .din(din), .cs_n(cs_n), .dout(dout),
        .dout_oe_n(dout_oe_n));
    initial begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end
    function automatic logic [31:0] lfsr(input logic [31:0] x);
        return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
    endfunction
    function automatic int width_of(input int sel);
        return (sel == 4) ? 16 : 8;
    endfunction
    function automatic logic [15:0] out_of(input int sel);
        case (sel)
            1: return {8'h00, op_config};
            2: return {8'h00, main_conv_ctl};
            3: return {8'h00, aux_conv_ctl};
            4: return port_excite_ctl;
            5: return {8'h00, decimation_ratio};
            default: return {8'h00, conv_status};
        endcase
    endfunction
    function automatic logic [15:0] exp_of(input int sel);
        if (sel == 0) return {8'h00, pins[6:1], 1'b0, pins[0]};
        if (sel > 5) return 16'h0000;
        return model[sel][15:0];
    endfunction
    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic wr(input int sel, input logic [15:0] val);
        u_host_link_model.xfer({24'h000000, 4'h0, sel[3:0]}, 8, rx, oe);
        u_host_link_model.xfer({16'h0000, val}, width_of(sel), rx, oe);
        chk("enable in write", 16'h0000, oe[15:0]);
        if (sel >= 1 && sel <= 5) model[sel] = val & mask[sel];
    endtask
    task automatic rd(input int sel);
        u_host_link_model.xfer({24'h000000, 4'h4, sel[3:0]}, 8, rx, oe);
        u_host_link_model.xfer(32'h00000000, width_of(sel), rx, oe);
        chk($sformatf("read of %0d", sel), exp_of(sel), rx[15:0]);
        chk("enable in read", 16'(width_of(sel)), oe[15:0]);
    endtask
    task automatic report_and_stop;
        $display("checks %0d error_cnt %0d", checks, error_cnt);
        if (error_cnt == 0 && checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    initial begin
        repeat (90000) @(posedge ref_clk);
        error_cnt++;
        report_and_stop;
    end
    initial begin
        reset_n = 1'b0;
        pins = 7'h00;
        error_cnt = 0;
        checks = 0;
        seed = 32'hCAFEC071;
        foreach (model[i]) model[i] = rst[i];
        repeat (4) @(posedge ref_clk);
        @(negedge ref_clk) reset_n = 1'b1;
        repeat (3) @(negedge ref_clk);
        for (int s = 0; s < 6; s++) chk("reset value", exp_of(s), out_of(s));
        for (int s = 0; s < 6; s++) rd(s);
        repeat (2) begin
            for (int s = 1; s < 6; s++) begin
                seed = lfsr(seed);
                wr(s, seed[15:0]);
                chk("register output", exp_of(s), out_of(s));
                rd(s);
            end
        end
        // mid-run reset must bring every register back to its default
        @(negedge ref_clk) reset_n = 1'b0;
        repeat (4) @(negedge ref_clk);
        reset_n = 1'b1;
        repeat (3) @(negedge ref_clk);
        foreach (model[i]) model[i] = rst[i];
        for (int s = 0; s < 6; s++) chk("after reset", exp_of(s), out_of(s));
        rd(3);
        // status pins change only between frames, before a dropped write
        pins = seed[22:16];
        wr(0, 16'h00FF);
        rd(0);
        chk("status output", exp_of(0), out_of(0));
        // gated command must not open a transfer to the filter ratio
        u_host_link_model.xfer(32'h00000085, 8, rx, oe);
        wr(1, 16'h002A);
        chk("gated command", exp_of(5), out_of(5));
        rd(1);
        foreach (unmapped_q[i]) begin
            wr(unmapped_q[i], 16'h00FF);
            rd(unmapped_q[i]);
        end
        rd(2);
        // resync in mid-transfer: 8 ones land in main control, the reset must undo them
        u_host_link_model.xfer(32'h00000002, 8, rx, oe);
        u_host_link_model.xfer(32'hFFFFFFFF, 32, rx, oe);
        repeat (4) @(negedge ref_clk);
        foreach (model[i]) model[i] = rst[i];
        for (int s = 1; s < 6; s++) chk("after resync", exp_of(s), out_of(s));
        rd(5);
        report_and_stop;
    end
endmodule
`default_nettype wire
